// ==== inc/radio_mode_map.svh ====
`ifndef RADIO_MODE_MAP_SVH
`define RADIO_MODE_MAP_SVH

// apb register byte offsets
`define CTRL_OFS       8'h00
`define ADDR_OFS       8'h04
`define STAT_OFS       8'h08

// field positions
`define CTRL_WOR_TX_BIT 0
`define ADDR_OWN_LSB    0
`define ADDR_CHAN_LSB   16
`define STAT_MODE_LSB   0
`define STAT_IDLE_BIT   2
`define STAT_STATE_LSB  3
`define STAT_FILL_LSB   16

// reset values of the stored user parameters, and the broadcast address
`define CTRL_RST       1'h0
`define OWN_ADDR_RST   16'h0000
`define CHAN_RST       8'h00
`define BCAST_ADDR     16'hffff

// timing, in microseconds, and clock rate in MHz
`define CLK_MHZ        25
`define SWITCH_TIME_US 1000
`define HOLD_TIME_US   2000
`define INIT_TIME_US   100
`define RELOAD_TIME_US 100

`define BUF_DEPTH      1000

`endif

// ==== inc/radio_mode_pkg.sv ====
package radio_mode_pkg;

   // gray order along init -> run -> reload
   typedef enum logic [1:0] {
      ST_INIT   = 2'b00,
      ST_RUN    = 2'b01,
      ST_RELOAD = 2'b11
   } ctl_state_t;

   typedef enum logic [1:0] {
      MD_NORMAL = 2'b00,
      MD_WOR    = 2'b01,
      MD_CONFIG = 2'b10,
      MD_SLEEP  = 2'b11
   } work_mode_t;

endpackage

// ==== verilog/tx_byte_mem.sv ====
`timescale 1ns/10ps
module tx_byte_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 1000,
   parameter int AW    = 10
) (
   input  logic             clk,
   input  logic             we,
   input  logic [AW-1:0]    waddr,
   input  logic [WIDTH-1:0] wdata,
   input  logic [AW-1:0]    raddr,
   output logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // write-first bypass so a byte written while the buffer is empty shows next cycle
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (we && waddr == raddr) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule

// ==== verilog/radio_mode_status.sv ====
// Functional notes
// - two select pins pick modes 0-3
// - mode 0: uart and radio both open
// - mode 1: wake-on-radio sender or receiver
// - mode 2: host configures over serial port
// - mode 3: sleep
// - all-ones address transmits as broadcast
// - all-ones address receiver accepts any sender
// - power-on: indicator low, self-check, load params
// - init done: indicator high, run selected mode
// - indicator low while serial output active
// - indicator low while transmit buffer not empty
// - buffer takes bursts below capacity when idle
// - any low condition wins over high
// - mode pins ignored while busy
// - new mode only after 2ms idle
// - leaving sleep reloads params, indicator low
// - config phase shown only at reset/wake
// - idle mode change applies after 1ms
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "radio_mode_map.svh"
module radio_mode_status
   import radio_mode_pkg::*;
#(
   parameter int DEPTH      = `BUF_DEPTH,
   parameter int SWITCH_CYC = `SWITCH_TIME_US * `CLK_MHZ,
   parameter int HOLD_CYC   = `HOLD_TIME_US * `CLK_MHZ,
   parameter int INIT_CYC   = `INIT_TIME_US * `CLK_MHZ,
   parameter int RELOAD_CYC = `RELOAD_TIME_US * `CLK_MHZ
) (
   input  logic        CLK,
   input  logic        RST_N,
   input  logic        MODE_SELECT_LOW,
   input  logic        MODE_SELECT_HIGH,
   input  logic        PSEL,
   input  logic        PENABLE,
   input  logic        PWRITE,
   input  logic [7:0]  PADDR,
   input  logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic        PREADY,
   output logic        PSLVERR,
   input  logic        HOST_RX_VALID,
   input  logic [7:0]  HOST_RX_DATA,
   output logic        HOST_RX_READY,
   input  logic        SER_TX_ACTIVE,
   output logic        RADIO_TX_VALID,
   output logic [7:0]  RADIO_TX_DATA,
   input  logic        RADIO_TX_READY,
   output logic [15:0] RADIO_TX_ADDR,
   output logic [7:0]  RADIO_CHANNEL,
   input  logic        RADIO_RX_VALID,
   input  logic [15:0] RADIO_RX_ADDR,
   input  logic [7:0]  RADIO_RX_CHANNEL,
   output logic        RX_ACCEPT,
   output logic [1:0]  MODE,
   output logic        UART_EN,
   output logic        RADIO_EN,
   output logic        WOR_TX_EN,
   output logic        WOR_RX_EN,
   output logic        CFG_EN,
   output logic        SLEEP,
   output logic        IDLE_IND
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   typedef struct packed {
      logic [1:0]  sel_meta;
      logic [1:0]  sel_sync;
      logic [1:0]  sel_prev;
      ctl_state_t  st;
      work_mode_t  mode;
      logic [15:0] tmr;
      logic [15:0] hi_cnt;
      logic [15:0] chg_cnt;
      logic        idle;
      logic        accept;
      logic        wor_tx;
      logic [15:0] own_addr;
      logic [7:0]  chan;
      logic [31:0] prdata;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } status_t;

   status_t cur_reg;
   status_t cur_next;

   logic          busy;
   logic          push;
   logic          pop;
   logic          run_data;
   logic          apply;
   logic          unmapped;
   logic [AW-1:0] raddr;
   logic [31:0]   rd_word;

   assign run_data = cur_reg.st == ST_RUN &&
                     (cur_reg.mode == MD_NORMAL || cur_reg.mode == MD_WOR);
   // pins settle as one 2-bit word; a change counts only once both stages agree
   assign apply    = cur_reg.st == ST_RUN && cur_reg.idle &&
                     cur_reg.sel_sync == cur_reg.sel_prev &&
                     work_mode_t'(cur_reg.sel_sync) != cur_reg.mode &&
                     cur_reg.chg_cnt >= 16'(SWITCH_CYC) &&
                     cur_reg.hi_cnt >= 16'(HOLD_CYC);

   assign HOST_RX_READY  = run_data && cur_reg.cnt != FULL_CNT;
   assign push           = HOST_RX_VALID && HOST_RX_READY;
   assign RADIO_TX_VALID = RADIO_EN && cur_reg.cnt != '0;
   assign pop            = RADIO_TX_VALID && RADIO_TX_READY;
   assign raddr          = pop ? ((cur_reg.rp == LAST_IDX) ? '0 : cur_reg.rp + 1'b1)
                               : cur_reg.rp;

   assign busy = cur_reg.st != ST_RUN ||
                 SER_TX_ACTIVE ||
                 cur_reg.cnt != '0;

   assign unmapped = PADDR != `CTRL_OFS && PADDR != `ADDR_OFS && PADDR != `STAT_OFS;

   always_comb begin
      rd_word = '0;
      case (PADDR)
         `CTRL_OFS: begin
            rd_word[`CTRL_WOR_TX_BIT] = cur_reg.wor_tx;
         end
         `ADDR_OFS: begin
            rd_word[`ADDR_OWN_LSB +: 16] = cur_reg.own_addr;
            rd_word[`ADDR_CHAN_LSB +: 8] = cur_reg.chan;
         end
         `STAT_OFS: begin
            rd_word[`STAT_MODE_LSB +: 2]  = cur_reg.mode;
            rd_word[`STAT_IDLE_BIT]       = cur_reg.idle;
            rd_word[`STAT_STATE_LSB +: 2] = cur_reg.st;
            rd_word[`STAT_FILL_LSB +: CW] = cur_reg.cnt;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   always_comb begin
      cur_next          = cur_reg;
      cur_next.sel_meta = {MODE_SELECT_HIGH, MODE_SELECT_LOW};
      cur_next.sel_sync = cur_reg.sel_meta;
      cur_next.sel_prev = cur_reg.sel_sync;
      cur_next.idle     = !busy;

      if (!cur_reg.idle) begin
         cur_next.hi_cnt = '0;
      end else if (cur_reg.hi_cnt != 16'hffff) begin
         cur_next.hi_cnt = cur_reg.hi_cnt + 16'h0001;
      end

      // while busy the pins are not looked at: the settle count only runs when idle
      if (!cur_reg.idle || cur_reg.sel_sync != cur_reg.sel_prev ||
          work_mode_t'(cur_reg.sel_sync) == cur_reg.mode) begin
         cur_next.chg_cnt = '0;
      end else if (cur_reg.chg_cnt != 16'hffff) begin
         cur_next.chg_cnt = cur_reg.chg_cnt + 16'h0001;
      end

      case (cur_reg.st)
         ST_INIT: begin
            cur_next.tmr = cur_reg.tmr + 16'h0001;
            if (cur_reg.tmr >= 16'(INIT_CYC - 1)) begin
               cur_next.st   = ST_RUN;
               cur_next.mode = work_mode_t'(cur_reg.sel_sync);
               cur_next.tmr  = '0;
            end
         end
         ST_RUN: begin
            if (apply) begin
               cur_next.mode = work_mode_t'(cur_reg.sel_sync);
               if (cur_reg.mode == MD_SLEEP) begin
                  cur_next.st  = ST_RELOAD;
                  cur_next.tmr = '0;
               end
            end
         end
         ST_RELOAD: begin
            cur_next.tmr = cur_reg.tmr + 16'h0001;
            if (cur_reg.tmr >= 16'(RELOAD_CYC - 1)) begin
               cur_next.st  = ST_RUN;
               cur_next.tmr = '0;
            end
         end
         default: begin
            cur_next.st  = ST_INIT;
            cur_next.tmr = '0;
         end
      endcase

      // transmit buffer pointers
      if (push) begin
         cur_next.wp = (cur_reg.wp == LAST_IDX) ? '0 : cur_reg.wp + 1'b1;
      end
      if (pop) begin
         cur_next.rp = raddr;
      end
      if (push && !pop) begin
         cur_next.cnt = cur_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         cur_next.cnt = cur_reg.cnt - 1'b1;
      end

      // all-ones own address listens to every sender on its channel; all-ones sender reaches every listener on that channel
      cur_next.accept = RADIO_RX_VALID && RADIO_EN && RADIO_RX_CHANNEL == cur_reg.chan &&
                        (cur_reg.own_addr == `BCAST_ADDR ||
                         RADIO_RX_ADDR == `BCAST_ADDR ||
                         RADIO_RX_ADDR == cur_reg.own_addr);

      // apb: read data captured in setup, write lands in access
      if (PSEL && !PENABLE) begin
         cur_next.prdata = rd_word;
      end
      if (PSEL && PENABLE && PWRITE) begin
         if (PADDR == `CTRL_OFS) begin
            cur_next.wor_tx = PWDATA[`CTRL_WOR_TX_BIT];
         end
         if (PADDR == `ADDR_OFS) begin
            cur_next.own_addr = PWDATA[`ADDR_OWN_LSB +: 16];
            cur_next.chan     = PWDATA[`ADDR_CHAN_LSB +: 8];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cur_reg          <= '0;
         cur_reg.st       <= ST_INIT;
         cur_reg.mode     <= MD_NORMAL;
         cur_reg.idle     <= 1'b0;
         cur_reg.wor_tx   <= `CTRL_RST;
         cur_reg.own_addr <= `OWN_ADDR_RST;
         cur_reg.chan     <= `CHAN_RST;
      end else begin
         cur_reg <= cur_next;
      end
   end

   tx_byte_mem #(
      .WIDTH (8),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_buf (
      .clk   (CLK),
      .we    (push),
      .waddr (cur_reg.wp),
      .wdata (HOST_RX_DATA),
      .raddr (raddr),
      .rdata (RADIO_TX_DATA)
   );

   assign PRDATA        = cur_reg.prdata;
   assign PREADY        = 1'b1;
   assign PSLVERR       = PSEL && PENABLE &&
                          (unmapped || (PWRITE && PADDR == `STAT_OFS));
   assign RADIO_TX_ADDR = cur_reg.own_addr;
   assign RADIO_CHANNEL = cur_reg.chan;
   assign RX_ACCEPT     = cur_reg.accept;
   assign MODE          = cur_reg.mode;
   assign IDLE_IND      = cur_reg.idle;
   assign UART_EN       = cur_reg.st == ST_RUN && cur_reg.mode != MD_SLEEP;
   assign RADIO_EN      = cur_reg.st == ST_RUN &&
                          (cur_reg.mode == MD_NORMAL || cur_reg.mode == MD_WOR);
   assign WOR_TX_EN     = cur_reg.st == ST_RUN && cur_reg.mode == MD_WOR &&
                          cur_reg.wor_tx;
   assign WOR_RX_EN     = cur_reg.st == ST_RUN && cur_reg.mode == MD_WOR && !cur_reg.wor_tx;
   assign CFG_EN        = cur_reg.st == ST_RUN && cur_reg.mode == MD_CONFIG;
   assign SLEEP         = cur_reg.st == ST_RUN && cur_reg.mode == MD_SLEEP;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_init_done;
      cur_reg.st == ST_INIT ##1 cur_reg.st == ST_RUN;
   endsequence
   sequence s_leave_sleep;
      cur_reg.st == ST_RUN && cur_reg.mode == MD_SLEEP ##1 cur_reg.mode != MD_SLEEP;
   endsequence
   property p_init_low;
      cur_reg.st == ST_INIT |=> !IDLE_IND;
   endproperty
   a_init_low: assert property (p_init_low) else $error("idle high during self-check");
   // the indicator follows the serial line of the cycle before
   property p_init_mode;
      s_init_done |-> MODE == $past(cur_reg.sel_sync) ##1 IDLE_IND || $past(SER_TX_ACTIVE);
   endproperty
   a_init_mode: assert property (p_init_mode) else $error("wrong mode after init");
   property p_ser_low;
      SER_TX_ACTIVE |=> !IDLE_IND;
   endproperty
   a_ser_low: assert property (p_ser_low) else $error("idle high during serial output");
   property p_buf_low;
      RADIO_TX_VALID |=> !IDLE_IND;
   endproperty
   a_buf_low: assert property (p_buf_low) else $error("idle high with buffer data");
   property p_idle_high;
      cur_reg.st == ST_RUN && !SER_TX_ACTIVE && cur_reg.cnt == '0 |=> IDLE_IND;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle low with no busy cause");
   property p_busy_hold;
      !IDLE_IND && cur_reg.st == ST_RUN |=> $stable(MODE);
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("mode changed while busy");
   // the first mode after init is not a switch; leaving sleep is
   property p_hold_2ms;
      $past(cur_reg.st) == ST_RUN && $changed(MODE) |->
         $past(cur_reg.hi_cnt) >= 16'(HOLD_CYC) && $past(IDLE_IND);
   endproperty
   a_hold_2ms: assert property (p_hold_2ms) else $error("mode applied before hold time");
   property p_wake_reload;
      s_leave_sleep |-> cur_reg.st == ST_RELOAD ##1 !IDLE_IND [*2];
   endproperty
   a_wake_reload: assert property (p_wake_reload) else $error("no reload after sleep");
   property p_listen;
      RADIO_RX_VALID && RADIO_EN && RADIO_RX_CHANNEL == RADIO_CHANNEL &&
         RADIO_TX_ADDR == `BCAST_ADDR |=> RX_ACCEPT;
   endproperty
   a_listen: assert property (p_listen) else $error("listener dropped a frame");
   property p_room;
      run_data && cur_reg.cnt < FULL_CNT && HOST_RX_VALID && !pop |=>
         cur_reg.cnt == $past(cur_reg.cnt) + 1'b1;
   endproperty
   a_room: assert property (p_room) else $error("buffer refused below capacity");
   property p_sel_stable;
      $past(cur_reg.st) == ST_RUN && $changed(MODE) |->
         $past(cur_reg.sel_sync, 1) == $past(cur_reg.sel_sync, 2);
   endproperty
   a_sel_stable: assert property (p_sel_stable) else $error("mode from unsettled pins");
endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/10ps
module host_model (
   input  logic       clk,
   input  logic       host_rx_ready,
   output logic       mode_select_low,
   output logic       mode_select_high,
   output logic       host_rx_valid,
   output logic [7:0] host_rx_data
);
   logic [7:0] sent_q[$];

   initial begin
      mode_select_low = 1'b0;
      mode_select_high = 1'b0;
      host_rx_valid = 1'b0;
      host_rx_data = 8'h00;
   end

   // an idle data line keeps changing, so a stale byte is never mistaken for a real one
   always @(posedge clk) begin
      if (!host_rx_valid) begin
         host_rx_data <= 8'($urandom);
      end
   end

   task automatic set_mode(input logic [1:0] m);
      @(posedge clk);
      mode_select_high <= m[1];
      mode_select_low  <= m[0];
   endtask

   // bursts stay short; the radio side may still be busy when the indicator is high
   task automatic burst(input int n, output int taken);
      taken = 0;
      @(posedge clk);
      host_rx_valid <= 1'b1;
      repeat (n) begin
         @(posedge clk);
         if (host_rx_ready === 1'b1) begin
            sent_q.push_back(host_rx_data);
            taken++;
            host_rx_data <= 8'($urandom);
         end
      end
      host_rx_valid <= 1'b0;
   endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench
   import radio_mode_pkg::*;
();
   localparam int DEPTH = 8;
   localparam int SW    = 20;
   localparam int HOLD  = 40;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, hdata, rtx_data, rchan, rrx_chan;
   logic [31:0] pwdata, prdata, rd;
   logic        msl, msh, hvalid, hready, ser_tx, rtx_valid, rtx_ready, rrx_valid;
   logic [15:0] rtx_addr, rrx_addr;
   logic        rx_accept, uart_en, radio_en, wor_tx_en, wor_rx_en, cfg_en, sleep_o;
   logic [1:0]  mode;
   logic        idle_ind, drain_en, err, low;
   int          miscompares, check_count, t, n, cyc;
   logic [23:0] fr[6] = '{24'h04_1234, 24'h04_ffff, 24'h04_4321, 24'h05_1234,
                          24'h04_4321, 24'h05_1234};
   logic [5:0]  fr_ok = 6'b010011;

   radio_mode_status #(.DEPTH(DEPTH), .SWITCH_CYC(SW), .HOLD_CYC(HOLD), .INIT_CYC(8),
      .RELOAD_CYC(8)) i_dut (.CLK(clk), .RST_N(rst_n), .MODE_SELECT_LOW(msl),
      .MODE_SELECT_HIGH(msh), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .HOST_RX_VALID(hvalid), .HOST_RX_DATA(hdata),
      .HOST_RX_READY(hready), .SER_TX_ACTIVE(ser_tx), .RADIO_TX_VALID(rtx_valid),
      .RADIO_TX_DATA(rtx_data), .RADIO_TX_READY(rtx_ready), .RADIO_TX_ADDR(rtx_addr),
      .RADIO_CHANNEL(rchan), .RADIO_RX_VALID(rrx_valid), .RADIO_RX_ADDR(rrx_addr),
      .RADIO_RX_CHANNEL(rrx_chan), .RX_ACCEPT(rx_accept), .MODE(mode),
      .UART_EN(uart_en), .RADIO_EN(radio_en), .WOR_TX_EN(wor_tx_en),
      .WOR_RX_EN(wor_rx_en), .CFG_EN(cfg_en), .SLEEP(sleep_o), .IDLE_IND(idle_ind));

   host_model i_host (.clk(clk), .host_rx_ready(hready), .mode_select_low(msl),
      .mode_select_high(msh), .host_rx_valid(hvalid), .host_rx_data(hdata));

   always #20 clk = ~clk;

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle(input int lim);
      n = 0;
      while (idle_ind !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic goto(input logic [1:0] m);
      cyc = 0;
      low = 1'b0;
      i_host.set_mode(m);
      while (mode !== m && cyc < 500) begin
         @(posedge clk);
         cyc++;
         if (idle_ind === 1'b0) low = 1'b1;
      end
      chk("mode", 32'(mode), 32'(m));
   endtask

   task automatic rx(input logic [23:0] f, input logic e);
      @(posedge clk);
      rrx_valid <= 1'b1;
      {rrx_chan, rrx_addr} <= f;
      @(posedge clk);
      rrx_valid <= 1'b0;
      {rrx_chan, rrx_addr} <= ~f;
      @(posedge clk);
      chk("rx_accept", 32'(rx_accept), 32'(e));
   endtask

   // the radio stalls at random while draining and completely otherwise
   always @(posedge clk) rtx_ready <= drain_en & 1'($urandom);

   always @(posedge clk) begin
      if (rtx_valid === 1'b1 && rtx_ready === 1'b1) begin
         if (i_host.sent_q.size() == 0) chk("radio_extra", 32'h1, 32'h0);
         else chk("radio_byte", 32'(rtx_data), 32'(i_host.sent_q.pop_front()));
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {psel, penable, pwrite, ser_tx, rtx_ready, rrx_valid, drain_en} = '0;
      {paddr, pwdata, rrx_addr, rrx_chan} = '0;
      void'($urandom(41));
      repeat (12) @(posedge clk);
      chk("idle_rst", 32'(idle_ind), 32'h0);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("idle_init", 32'(idle_ind), 32'h0);
      wait_idle(50);
      chk("idle_up", 32'(idle_ind), 32'h1);
      chk("mode0", 32'({mode, uart_en, radio_en}), 32'h3);
      apb(1'b0, 8'h08, 32'h0);
      chk("status", rd, 32'h0000000c);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped", 32'(err), 32'h1);
      apb(1'b1, 8'h08, 32'hffffffff);
      chk("ro_write", 32'(err), 32'h1);
      i_host.burst(DEPTH - 1, t);
      chk("burst", t, DEPTH - 1);
      i_host.burst(6, t);
      chk("full", t, 1);
      chk("idle_buf", 32'(idle_ind), 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk("fill", 32'(rd[25:16]), DEPTH);
      i_host.set_mode(MD_CONFIG);
      repeat (SW + HOLD) @(posedge clk);
      chk("busy_mode", 32'(mode), 32'(MD_NORMAL));
      drain_en <= 1'b1;
      wait_idle(2000);
      chk("drained", i_host.sent_q.size(), 0);
      cyc = 0;
      while (mode !== MD_CONFIG && cyc < 500) begin
         @(posedge clk);
         cyc++;
      end
      chk("hold", 32'(cyc >= HOLD && cyc <= HOLD + 5), 32'h1);
      chk("cfg", 32'(cfg_en), 32'h1);
      drain_en <= 1'b0;
      ser_tx <= 1'b1;
      repeat (3) @(posedge clk);
      chk("idle_ser", 32'(idle_ind), 32'h0);
      ser_tx <= 1'b0;
      wait_idle(5);
      chk("idle_back", 32'(idle_ind), 32'h1);
      repeat (HOLD + 5) @(posedge clk);
      apb(1'b1, 8'h00, 32'h1);
      goto(MD_WOR);
      chk("wor", 32'({wor_tx_en, wor_rx_en}), 32'h2);
      chk("switch", 32'(cyc >= SW && cyc <= SW + 10), 32'h1);
      chk("no_cfg1", 32'(low), 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      @(posedge clk);
      chk("wor_rx", 32'({wor_tx_en, wor_rx_en}), 32'h1);
      repeat (HOLD + 5) @(posedge clk);
      goto(MD_SLEEP);
      chk("sleep", 32'(sleep_o), 32'h1);
      chk("no_cfg3", 32'(low), 32'h0);
      goto(MD_NORMAL);
      // the indicator lags the state by one edge, so look just after the switch
      repeat (2) @(posedge clk);
      chk("reload", 32'(idle_ind), 32'h0);
      wait_idle(500);
      apb(1'b1, 8'h04, 32'h00041234);
      @(posedge clk);
      chk("tx_addr", 32'({rchan, rtx_addr}), 32'h00041234);
      for (int i = 0; i < 6; i++) begin
         if (i == 4) begin
            apb(1'b1, 8'h04, 32'h0004ffff);
            @(posedge clk);
            chk("bcast", 32'(rtx_addr), 32'h0000ffff);
         end
         rx(fr[i], fr_ok[i]);
      end
      print_verdict();
   end
endmodule
